/* rtl/meas_pkg.sv */
package meas_pkg;

	// Time base
	localparam int unsigned CLK_HZ        = 40_000_000;
	localparam int unsigned TICK_MS       = 50;
	localparam int unsigned TICK_CYC      = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned TICKS_PER_SEC = 1000 / TICK_MS;
	localparam int unsigned MIN_TIMER_SEC = 10;
	localparam int unsigned MAX_RUN_SEC   = 9999 * 3600 + 59 * 60 + 59;

	// Register byte offsets
	localparam logic [4:0] OFS_CTRL      = 5'h00;
	localparam logic [4:0] OFS_TMR_DUR   = 5'h04;
	localparam logic [4:0] OFS_TMR_ADJ   = 5'h08;
	localparam logic [4:0] OFS_RTC_NOW   = 5'h0C;
	localparam logic [4:0] OFS_WIN_START = 5'h10;
	localparam logic [4:0] OFS_WIN_STOP  = 5'h14;
	localparam logic [4:0] OFS_STATUS    = 5'h18;
	localparam logic [4:0] OFS_ELAPSED   = 5'h1C;

	// Control fields
	localparam int unsigned CTRL_IVL_LSB = 0;
	localparam int unsigned CTRL_TMR_BIT = 4;
	localparam int unsigned CTRL_RTC_BIT = 5;
	localparam int unsigned CTRL_AVG_LSB = 6;
	localparam int unsigned ADJ_OP_LSB   = 0;
	localparam int unsigned ADJ_GRP_LSB  = 2;
	localparam logic [2:0]  AVG_LVL_MAX  = 3'h5;

	// Reset values
	localparam logic [25:0] RST_TMR_DUR = 26'h0000E10;
	localparam logic [3:0]  RST_IVL     = 4'h0;
	localparam logic [2:0]  RST_AVG     = 3'h0;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_ARMED = 5'b00010,
		ST_RUN   = 5'b00100,
		ST_PAUSE = 5'b01000,
		ST_DONE  = 5'b10000
	} run_state_e;

	typedef logic signed [15:0] val_t;

	typedef struct packed {
		val_t [1:0] ch;
	} pair_s;

	// Interval period in 50 ms ticks, zero for off
	function automatic logic [16:0] ivl_ticks(input logic [3:0] code);
		unique case (code)
			4'h1:    ivl_ticks = 17'h00001;
			4'h2:    ivl_ticks = 17'h00002;
			4'h3:    ivl_ticks = 17'h00004;
			4'h4:    ivl_ticks = 17'h0000A;
			4'h5:    ivl_ticks = 17'h00014;
			4'h6:    ivl_ticks = 17'h00064;
			4'h7:    ivl_ticks = 17'h000C8;
			4'h8:    ivl_ticks = 17'h0012C;
			4'h9:    ivl_ticks = 17'h00258;
			4'hA:    ivl_ticks = 17'h004B0;
			4'hB:    ivl_ticks = 17'h01770;
			4'hC:    ivl_ticks = 17'h02EE0;
			4'hD:    ivl_ticks = 17'h04650;
			4'hE:    ivl_ticks = 17'h08CA0;
			4'hF:    ivl_ticks = 17'h11940;
			default: ivl_ticks = 17'h00000;
		endcase
	endfunction : ivl_ticks

	// Smoothing shift per averaging level
	function automatic logic [3:0] avg_shift(input logic [2:0] lvl);
		unique case (lvl)
			3'h1:    avg_shift = 4'h1;
			3'h2:    avg_shift = 4'h2;
			3'h3:    avg_shift = 4'h4;
			3'h4:    avg_shift = 4'h6;
			default: avg_shift = 4'h8;
		endcase
	endfunction : avg_shift

	function automatic logic [15:0] mag(input val_t v);
		mag = v[15] ? 16'(-v) : 16'(v);
	endfunction : mag

endpackage : meas_pkg

/* rtl/meas_timing_hold.sv */
// The register addresses and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
module meas_timing_hold #(
	parameter int unsigned TICK_CYCLES = meas_pkg::TICK_CYC
) (
	// Clock and reset
	input  wire logic            i_clk_sys,
	input  wire logic            i_rst_n,
	// AHB-Lite slave
	input  wire logic            i_hsel,
	input  wire logic [31:0]     i_haddr,
	input  wire logic [1:0]      i_htrans,
	input  wire logic            i_hwrite,
	input  wire logic [2:0]      i_hsize,
	input  wire logic [31:0]     i_hwdata,
	input  wire logic            i_hready,
	output logic [31:0]          o_hrdata,
	output logic                 o_hreadyout,
	output logic                 o_hresp,
	// Operator keys, asynchronous pins
	input  wire logic            i_start_key,
	input  wire logic            i_hold_key,
	input  wire logic            i_shift_hold_key,
	input  wire logic            i_data_reset_key,
	// Measurement stream
	input  wire meas_pkg::pair_s i_meas,
	input  wire logic            i_meas_bypass,
	input  wire meas_pkg::pair_s i_wave,
	input  wire logic [3:0]      i_range,
	// Outputs
	output logic                 o_tick_50ms,
	output logic                 o_integ_run,
	output logic                 o_ivl_edge,
	output logic                 o_save_strobe,
	output meas_pkg::pair_s      o_out_data,
	output meas_pkg::pair_s      o_wave_out,
	output logic [3:0]           o_range,
	output logic                 o_data_hold,
	output logic                 o_peak_hold
);
	import meas_pkg::*;

	typedef struct packed {
		logic [21:0] div;
		logic        tick;
		logic [4:0]  rtc_sub;
		logic [31:0] rtc;
		logic [4:0]  run_sub;
		logic [25:0] elapsed;
		logic [16:0] ivl_cnt;
		logic        ivl_edge;
		logic        save;
		run_state_e  st;
		logic [3:0]  ivl_code;
		logic        tmr_en;
		logic        rtc_en;
		logic [2:0]  avg_lvl;
		logic [25:0] dur;
		logic [31:0] win_start;
		logic [31:0] win_stop;
		logic        data_hold;
		logic        peak_hold;
		logic [3:0]  range_frz;
		logic [3:0]  range;
		pair_s       avg;
		pair_s       peak;
		pair_s       disp;
		pair_s       wave;
		logic [3:0][2:0] key_sync;
		logic        ap_wr;
		logic        ap_rd;
		logic [4:0]  ap_addr;
		logic [31:0] hrdata;
		logic        hready;
	} state_s;

	state_s      s_q;
	state_s      s_d;
	logic [3:0]  press;
	logic        ivl_ok;
	logic        end_now;
	logic [31:0] span;
	logic [16:0] per;
	logic        wr_ok;
	logic signed [16:0] diff;
	logic signed [26:0] adj;
	logic [25:0] unit;

	always_comb begin
		s_d = s_q;
		s_d.tick = 1'b0;
		s_d.ivl_edge = 1'b0;
		s_d.save = 1'b0;
		diff = '0;
		adj = '0;
		unit = 26'h0000001;
		// Key synchronisers and rising-edge detect
		for (int k = 0; k < 4; k++) begin
			s_d.key_sync[k] = {s_q.key_sync[k][1:0], 1'b0};
			press[k] = s_q.key_sync[k][1] & ~s_q.key_sync[k][2];
		end
		s_d.key_sync[0][0] = i_start_key;
		s_d.key_sync[1][0] = i_hold_key;
		s_d.key_sync[2][0] = i_shift_hold_key;
		s_d.key_sync[3][0] = i_data_reset_key;
		// Free-running 50 ms base and real-time clock
		if (s_q.div == 22'(TICK_CYCLES - 1)) begin
			s_d.div = '0;
			s_d.tick = 1'b1;
		end else begin
			s_d.div = s_q.div + 22'h000001;
		end
		if (s_q.tick) begin
			if (s_q.rtc_sub == 5'(TICKS_PER_SEC - 1)) begin
				s_d.rtc_sub = '0;
				s_d.rtc = s_q.rtc + 32'h00000001;
			end else begin
				s_d.rtc_sub = s_q.rtc_sub + 5'h01;
			end
		end
		// Interval admission against timer and window spans
		span = (s_q.win_stop > s_q.win_start) ? (s_q.win_stop - s_q.win_start) : 32'h0;
		per = ivl_ticks(s_q.ivl_code);
		ivl_ok = (per != 17'h0)
			&& !(s_q.tmr_en && {20'h0, per} > {11'h0, s_q.dur} * 37'd20)
			&& !(s_q.rtc_en && {20'h0, per} > {5'h0, span} * 37'd20);
		// End of run: timer wins, window stop ignored when longer than timer
		end_now = (s_q.st == ST_RUN) && (
			(s_q.tmr_en && s_q.elapsed >= s_q.dur)
			|| (s_q.rtc_en && s_q.rtc >= s_q.win_stop
				&& !(s_q.tmr_en && span > {6'h0, s_q.dur}))
			|| (!s_q.tmr_en && !s_q.rtc_en
				&& s_q.elapsed >= 26'(MAX_RUN_SEC)));
		unique case (s_q.st)
			ST_IDLE: begin
				if (press[0]) begin
					s_d.st = s_q.rtc_en ? ST_ARMED : ST_RUN;
					s_d.ivl_cnt = '0;
					s_d.run_sub = '0;
				end
			end
			ST_ARMED: begin
				if (s_q.rtc >= s_q.win_start) begin
					s_d.st = ST_RUN;
				end
			end
			ST_RUN: begin
				if (end_now) begin
					s_d.st = ST_DONE;
					s_d.save = 1'b1;
					s_d.rtc_en = 1'b0;
				end else if (press[0]) begin
					s_d.st = ST_PAUSE;
					if (s_q.rtc_en) begin
						s_d.rtc_en = 1'b0;
					end
				end else if (s_q.tick) begin
					if (s_q.run_sub == 5'(TICKS_PER_SEC - 1)) begin
						s_d.run_sub = '0;
						s_d.elapsed = s_q.elapsed + 26'h0000001;
					end else begin
						s_d.run_sub = s_q.run_sub + 5'h01;
					end
					if (ivl_ok && s_q.ivl_cnt == per - 17'h1) begin
						s_d.ivl_cnt = '0;
						s_d.ivl_edge = 1'b1;
						s_d.save = 1'b1;
					end else begin
						s_d.ivl_cnt = s_q.ivl_cnt + 17'h1;
					end
				end
			end
			ST_PAUSE: begin
				if (press[0]) begin
					s_d.st = ST_RUN;
				end else if (press[3]) begin
					s_d.st = ST_IDLE;
					s_d.elapsed = '0;
				end
			end
			ST_DONE: begin
				if (press[3]) begin
					s_d.st = ST_IDLE;
					s_d.elapsed = '0;
				end
			end
		endcase
		// Hold key handling
		if (press[2]) begin
			s_d.peak_hold = ~s_q.peak_hold;
			s_d.data_hold = 1'b0;
			s_d.peak = s_q.avg;
		end else if (press[1]) begin
			if (s_q.peak_hold) begin
				s_d.peak = '0;
			end else begin
				s_d.data_hold = ~s_q.data_hold;
				s_d.range_frz = s_q.range;
			end
		end
		// Averaging and peak tracking per component
		if (s_q.tick) begin
			for (int c = 0; c < 2; c++) begin
				diff = 17'(i_meas.ch[c]) - 17'(s_q.avg.ch[c]);
				if (i_meas_bypass || s_q.avg_lvl == 3'h0) begin
					s_d.avg.ch[c] = i_meas.ch[c];
				end else begin
					s_d.avg.ch[c] = s_q.avg.ch[c]
						+ 16'(diff >>> avg_shift(s_q.avg_lvl));
				end
			end
		end
		if (s_q.peak_hold && !press[1] && !press[2]) begin
			for (int c = 0; c < 2; c++) begin
				if (mag(s_q.avg.ch[c]) > mag(s_q.peak.ch[c])) begin
					s_d.peak.ch[c] = s_q.avg.ch[c];
				end
			end
			if (s_q.ivl_edge) begin
				s_d.peak = s_q.avg;
			end
		end
		// Presented data
		if (s_q.peak_hold) begin
			if (!ivl_ok || s_q.ivl_edge) begin
				s_d.disp = s_q.peak;
			end
		end else if (s_q.data_hold) begin
			if ((ivl_ok && s_d.ivl_edge) || (s_d.save && !ivl_ok)) begin
				s_d.disp = s_q.avg;
			end
		end else begin
			s_d.disp = s_q.avg;
		end
		s_d.wave = i_wave;
		s_d.range = s_q.data_hold ? s_q.range_frz : i_range;
		// AHB-Lite slave, reads take one wait state
		wr_ok = !s_q.data_hold && !s_q.peak_hold;
		if (s_q.ap_wr && wr_ok) begin
			unique case (s_q.ap_addr)
				OFS_CTRL: begin
					s_d.ivl_code = i_hwdata[CTRL_IVL_LSB +: 4];
					s_d.tmr_en = i_hwdata[CTRL_TMR_BIT];
					s_d.rtc_en = i_hwdata[CTRL_RTC_BIT];
					if (i_hwdata[CTRL_AVG_LSB +: 3] <= AVG_LVL_MAX) begin
						s_d.avg_lvl = i_hwdata[CTRL_AVG_LSB +: 3];
					end
				end
				OFS_TMR_DUR: begin
					if (i_hwdata >= 32'(MIN_TIMER_SEC) && i_hwdata <= 32'(MAX_RUN_SEC)) begin
						s_d.dur = i_hwdata[25:0];
					end
				end
				OFS_TMR_ADJ: begin
					unit = (i_hwdata[ADJ_GRP_LSB +: 2] == 2'h2) ? 26'h0000E10
						: (i_hwdata[ADJ_GRP_LSB +: 2] == 2'h1) ? 26'h000003C : 26'h0000001;
					adj = i_hwdata[ADJ_OP_LSB + 1] ? 27'(unit) * 27'd10 : 27'(unit);
					adj = i_hwdata[ADJ_OP_LSB] ? 27'({1'b0, s_q.dur}) - adj
						: 27'({1'b0, s_q.dur}) + adj;
					if (adj >= 27'(MIN_TIMER_SEC) && adj <= 27'(MAX_RUN_SEC)) begin
						s_d.dur = adj[25:0];
					end
				end
				OFS_RTC_NOW:   s_d.rtc = i_hwdata;
				OFS_WIN_START: s_d.win_start = i_hwdata;
				OFS_WIN_STOP:  s_d.win_stop = i_hwdata;
				default: ;
			endcase
		end
		s_d.ap_wr = 1'b0;
		s_d.hready = 1'b1;
		if (s_q.ap_rd) begin
			s_d.ap_rd = 1'b0;
			unique case (s_q.ap_addr)
				OFS_CTRL: s_d.hrdata = {23'h0, s_q.avg_lvl, s_q.rtc_en, s_q.tmr_en,
					s_q.ivl_code};
				OFS_TMR_DUR:   s_d.hrdata = {6'h0, s_q.dur};
				OFS_RTC_NOW:   s_d.hrdata = s_q.rtc;
				OFS_WIN_START: s_d.hrdata = s_q.win_start;
				OFS_WIN_STOP:  s_d.hrdata = s_q.win_stop;
				OFS_STATUS: s_d.hrdata = {20'h0, s_q.range_frz, ivl_ok, s_q.peak_hold,
					s_q.data_hold, s_q.st};
				OFS_ELAPSED:   s_d.hrdata = {6'h0, s_q.elapsed};
				default:       s_d.hrdata = 32'h00000000;
			endcase
		end else if (i_hsel && i_htrans[1] && i_hready) begin
			s_d.ap_addr = {i_haddr[4:2], 2'h0};
			s_d.ap_wr = i_hwrite;
			s_d.ap_rd = ~i_hwrite;
			s_d.hready = i_hwrite;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_q <= '0;
			s_q.st <= ST_IDLE;
			s_q.dur <= RST_TMR_DUR;
			s_q.ivl_code <= RST_IVL;
			s_q.avg_lvl <= RST_AVG;
			s_q.hready <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_hrdata = s_q.hrdata;
	assign o_hreadyout = s_q.hready;
	assign o_hresp = 1'b0;
	assign o_tick_50ms = s_q.tick;
	assign o_integ_run = (s_q.st == ST_RUN);
	assign o_ivl_edge = s_q.ivl_edge;
	assign o_save_strobe = s_q.save;
	assign o_out_data = s_q.disp;
	assign o_wave_out = s_q.wave;
	assign o_range = s_q.range;
	assign o_data_hold = s_q.data_hold;
	assign o_peak_hold = s_q.peak_hold;

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);

	sequence s_run_end;
		(s_q.st == ST_RUN) ##1 (s_q.st == ST_DONE);
	endsequence
	sequence s_pause_press;
		(s_q.st == ST_RUN) && press[0] && !end_now;
	endsequence

	property p_hold_excl;
		!(s_q.data_hold && s_q.peak_hold);
	endproperty
	a_hold_excl: assert property (p_hold_excl)
		else $error("both holds active");

	property p_no_write_in_hold;
		(s_q.data_hold && $past(s_q.data_hold)) |-> $stable(s_q.ivl_code) && $stable(s_q.dur);
	endproperty
	a_no_write_in_hold: assert property (p_no_write_in_hold)
		else $error("setting changed during hold");

	property p_avg_range;
		s_q.avg_lvl <= AVG_LVL_MAX;
	endproperty
	a_avg_range: assert property (p_avg_range)
		else $error("averaging level out of range");

	property p_dur_range;
		s_q.dur >= 26'(MIN_TIMER_SEC) && s_q.dur <= 26'(MAX_RUN_SEC);
	endproperty
	a_dur_range: assert property (p_dur_range)
		else $error("timer duration out of range");

	property p_wave_live;
		##1 o_wave_out == $past(i_wave);
	endproperty
	a_wave_live: assert property (p_wave_live)
		else $error("waveform output not live");

	property p_range_frozen;
		(s_q.data_hold && $past(s_q.data_hold)) |-> o_range == s_q.range_frz;
	endproperty
	a_range_frozen: assert property (p_range_frozen)
		else $error("range not frozen in hold");

	property p_pause;
		s_pause_press |=> (s_q.st == ST_PAUSE) && $stable(s_q.elapsed);
	endproperty
	a_pause: assert property (p_pause)
		else $error("start did not pause");

	property p_rtc_off_at_end;
		s_run_end |-> !s_q.rtc_en && s_q.save;
	endproperty
	a_rtc_off_at_end: assert property (p_rtc_off_at_end)
		else $error("clock control left on at end");

	property p_max_stop;
		(s_q.st == ST_RUN && !s_q.tmr_en && !s_q.rtc_en
			&& s_q.elapsed == 26'(MAX_RUN_SEC)) |=> (s_q.st == ST_DONE);
	endproperty
	a_max_stop: assert property (p_max_stop)
		else $error("no stop at maximum time");

	property p_ivl_refused;
		s_q.ivl_edge |-> $past(ivl_ok);
	endproperty
	a_ivl_refused: assert property (p_ivl_refused)
		else $error("interval edge while refused");

endmodule : meas_timing_hold

/* verification/meas_source.sv */
`timescale 1ns/1ps
// Measurement stream stand-in: a new sample after each 50 ms tick,
// and a waveform sample that moves every cycle
module meas_source (
	// Clock and reset
	input  wire logic            i_clk_sys,
	input  wire logic            i_rst_n,
	// Device side
	input  wire logic            i_tick,
	input  wire meas_pkg::pair_s i_next,
	output meas_pkg::pair_s      o_meas,
	output meas_pkg::pair_s      o_wave
);
	import meas_pkg::*;

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_meas <= '0;
			o_wave <= '0;
		end else begin
			o_wave <= {o_wave.ch[1] - 16'sh0003, o_wave.ch[0] + 16'sh0007};
			if (i_tick) begin
				o_meas <= i_next;
			end
		end
	end
endmodule : meas_source

/* verification/test_meas_timing_hold.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin n_mismatch++; \
	$display("MISMATCH %s expected %0h seen %0h", nm, ex, gt); end end
module test_meas_timing_hold;
	import meas_pkg::*;
	localparam int TICK = 20;
	typedef struct {
		logic [4:0]  wa;
		logic [31:0] wd;
		logic [4:0]  ra;
		logic [31:0] ex;
	} row_s;
	logic        clk, rst_n, hsel, hwrite, hreadyout, hresp, bypass;
	logic        tick, run, ivl, save, dhold, phold;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [3:0]  keys, rng, orng;
	pair_s       meas, wave, nxt, out, wout, w;
	int          n_mismatch, check_count, n;
	int          ivl_ms[1:5] = '{50, 100, 200, 500, 1000};
	logic [31:0] pk[3] = '{32'h000A_0032, 32'h0005_FFC4, 32'hFFEC_0028};
	row_s        rows[12] = '{
		'{OFS_CTRL, 32'h143, OFS_CTRL, 32'h143},
		'{OFS_CTRL, 32'h181, OFS_CTRL, 32'h141},
		'{OFS_TMR_DUR, 32'h9, OFS_TMR_DUR, 32'hE10},
		'{OFS_TMR_DUR, 32'hA, OFS_TMR_DUR, 32'hA},
		'{OFS_TMR_ADJ, 32'hA, OFS_TMR_DUR, 32'h8CAA},
		'{OFS_TMR_ADJ, 32'h1, OFS_TMR_DUR, 32'h8CA9},
		'{OFS_TMR_ADJ, 32'h6, OFS_TMR_DUR, 32'h8F01},
		'{OFS_TMR_ADJ, 32'hB, OFS_TMR_DUR, 32'h261},
		'{OFS_TMR_ADJ, 32'hB, OFS_TMR_DUR, 32'h261},
		'{OFS_TMR_DUR, 32'h22550FF, OFS_TMR_DUR, 32'h22550FF},
		'{OFS_TMR_DUR, 32'h2255100, OFS_TMR_DUR, 32'h22550FF},
		'{OFS_WIN_STOP, 32'h55, OFS_WIN_STOP, 32'h55}};

	meas_timing_hold #(.TICK_CYCLES(TICK)) i_dut (.i_clk_sys(clk), .i_rst_n(rst_n),
		.i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
		.i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata),
		.o_hreadyout(hreadyout), .o_hresp(hresp), .i_start_key(keys[0]),
		.i_hold_key(keys[1]), .i_shift_hold_key(keys[2]), .i_data_reset_key(keys[3]),
		.i_meas(meas), .i_meas_bypass(bypass), .i_wave(wave), .i_range(rng),
		.o_tick_50ms(tick), .o_integ_run(run), .o_ivl_edge(ivl), .o_save_strobe(save),
		.o_out_data(out), .o_wave_out(wout), .o_range(orng), .o_data_hold(dhold),
		.o_peak_hold(phold));
	meas_source i_src (.i_clk_sys(clk), .i_rst_n(rst_n), .i_tick(tick), .i_next(nxt),
		.o_meas(meas), .o_wave(wave));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic test_done;
		if (n_mismatch == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : test_done

	function automatic logic sig(input int s);
		sig = (s == 0) ? tick : (s == 1) ? ivl : (s == 2) ? run : !run;
	endfunction : sig

	// Cycles until the chosen signal is seen (tick, ivl or run high, or run low); a hang ends the run
	task automatic wait_on(input int s, input int lim, output int c);
		c = 0;
		do begin
			@(posedge clk);
			c++;
		end while (!sig(s) && c < lim);
		if (!sig(s)) begin
			`CHK("wait bound", 1'b1, sig(s))
			test_done();
		end
	endtask : wait_on

	task automatic bus_wait;
		int c;
		c = 0;
		do begin
			@(posedge clk);
			c++;
		end while (!hreadyout && c < 50);
		if (!hreadyout) begin
			`CHK("bus ready", 1'b1, hreadyout)
			test_done();
		end
	endtask : bus_wait

	task automatic ahb(input logic wr, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] r);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= {27'h0, a};
		hwrite <= wr;
		bus_wait();
		htrans <= 2'h0;
		hwdata <= d;
		bus_wait();
		r = hrdata;
	endtask : ahb

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] r;
		ahb(1'b1, a, d, r);
	endtask : wr

	task automatic rd_chk(input string nm, input logic [4:0] a, input logic [31:0] ex,
		input logic [31:0] m = 32'hFFFF_FFFF);
		logic [31:0] r;
		ahb(1'b0, a, 32'h0, r);
		`CHK(nm, ex, r & m)
	endtask : rd_chk

	task automatic press(input int k);
		keys[k] <= 1'b1;
		repeat (6) @(posedge clk);
		keys[k] <= 1'b0;
		repeat (6) @(posedge clk);
	endtask : press

	task automatic ticks(input int k);
		int c;
		repeat (k) wait_on(0, 3 * TICK, c);
		repeat (3) @(posedge clk);
	endtask : ticks

	initial begin
		n_mismatch = 0;
		check_count = 0;
		{rst_n, hsel, hwrite, bypass, keys, rng, haddr, hwdata, htrans} = '0;
		hsize = 3'h2;
		nxt = '0;
		repeat (2) @(posedge clk);
		`CHK("hreadyout in reset", 1'b1, hreadyout)
		rst_n <= 1'b1;
		@(posedge clk);
		rd_chk("ctrl reset", OFS_CTRL, 32'h0);
		rd_chk("duration reset", OFS_TMR_DUR, 32'hE10);
		rd_chk("state reset", OFS_STATUS, 32'h1, 32'h7F);
		rd_chk("adjust read", OFS_TMR_ADJ, 32'h0);
		foreach (rows[i]) begin
			wr(rows[i].wa, rows[i].wd);
			rd_chk("register row", rows[i].ra, rows[i].ex);
		end
		for (int c = 0; c < 16; c++) begin
			wr(OFS_CTRL, c);
			rd_chk("interval code", OFS_CTRL, c);
		end
		wr(OFS_CTRL, 32'h1);
		repeat (100) @(posedge clk);
		`CHK("run before start", 1'b0, run)
		press(0);
		for (int c = 1; c <= 5; c++) begin
			wr(OFS_CTRL, c);
			wait_on(1, 2000, n);
			wait_on(1, 2000, n);
			`CHK("interval period", ivl_ms[c] / TICK_MS * TICK, n)
		end
		press(0);
		press(3);
		rd_chk("elapsed cleared", OFS_ELAPSED, 32'h0);
		wr(OFS_TMR_DUR, 32'd11);
		wr(OFS_CTRL, 32'h18);
		rd_chk("interval refused", OFS_STATUS, 32'h0, 32'h80);
		wr(OFS_CTRL, 32'h16);
		rd_chk("interval allowed", OFS_STATUS, 32'h80, 32'h80);
		press(0);
		repeat (1000) @(posedge clk);
		press(0);
		rd_chk("paused", OFS_STATUS, 32'h8, 32'h7F);
		ahb(1'b0, OFS_ELAPSED, 32'h0, q);
		repeat (1000) @(posedge clk);
		rd_chk("value kept", OFS_ELAPSED, q);
		press(0);
		wait_on(3, 8000, n);
		rd_chk("timer end", OFS_ELAPSED, 32'd11);
		rd_chk("done", OFS_STATUS, 32'h10, 32'h7F);
		press(3);
		wr(OFS_RTC_NOW, 32'd100);
		wr(OFS_WIN_START, 32'd102);
		wr(OFS_WIN_STOP, 32'd130);
		wr(OFS_TMR_DUR, 32'd10);
		wr(OFS_CTRL, 32'h30);
		press(0);
		rd_chk("armed", OFS_STATUS, 32'h2, 32'h7F);
		wait_on(2, 4000, n);
		wait_on(3, 8000, n);
		rd_chk("window over timer", OFS_ELAPSED, 32'd10);
		rd_chk("clock off at end", OFS_CTRL, 32'h10);
		press(3);
		wr(OFS_RTC_NOW, 32'd200);
		wr(OFS_WIN_START, 32'd201);
		wr(OFS_WIN_STOP, 32'd240);
		wr(OFS_CTRL, 32'h30);
		press(0);
		wait_on(2, 4000, n);
		press(0);
		rd_chk("clock off on pause", OFS_CTRL, 32'h10);
		press(3);
		wait_on(0, 100, n);
		wait_on(0, 100, n);
		`CHK("tick period", TICK, n)
		wr(OFS_CTRL, 32'h40);
		ticks(20);
		nxt <= 32'hFC00_0400;
		ticks(2);
		`CHK("smooth step one", 32'hFE00_0200, out)
		ticks(1);
		`CHK("smooth step two", 32'hFD00_0300, out)
		bypass <= 1'b1;
		nxt <= 32'hFED4_FED4;
		ticks(2);
		`CHK("bypass", 32'hFED4_FED4, out)
		bypass <= 1'b0;
		wr(OFS_CTRL, 32'h0);
		nxt <= 32'hFF9C_0064;
		rng <= 4'h5;
		ticks(2);
		`CHK("averaging off", 32'hFF9C_0064, out)
		press(1);
		`CHK("data hold", 1'b1, dhold)
		nxt <= 32'h00C8_00C8;
		rng <= 4'h9;
		ticks(3);
		`CHK("held data", 32'hFF9C_0064, out)
		`CHK("frozen range", 4'h5, orng)
		@(negedge clk);
		w = wave;
		@(negedge clk);
		`CHK("live wave", w, wout)
		wr(OFS_CTRL, 32'h47);
		rd_chk("write in hold", OFS_CTRL, 32'h0);
		nxt <= '0;
		ticks(2);
		press(2);
		`CHK("hold states", 2'b01, {dhold, phold})
		foreach (pk[i]) begin
			nxt <= pk[i];
			ticks(2);
		end
		`CHK("peak values", 32'hFFEC_FFC4, out)
		wr(OFS_CTRL, 32'h47);
		rd_chk("write in peak", OFS_CTRL, 32'h0);
		nxt <= 32'hFFFC_0003;
		ticks(2);
		press(1);
		ticks(2);
		`CHK("peak restart", 32'hFFFC_0003, out)
		press(2);
		`CHK("peak off", 1'b0, phold)
		test_done();
	end
endmodule : test_meas_timing_hold
